// ==== reg_master_model.sv ====
// bus master model that turns register transfers into front-end requests
`timescale 1ns/10ps
`default_nettype none

module reg_master_model (
  input  wire logic               mclk,
  input  wire logic [31:0]        rdata,
  input  wire logic               rvalid,
  output var sscr_pkg::reg_req_t  req
);
  // ----------------------------------------
  // transfers
  // ----------------------------------------
  initial req = '0;

  // n data bytes lsb first after the address byte, so only low lanes are ever enabled
  task automatic put(input logic wr, input logic [7:0] addr, input int n,
                     input logic [31:0] data);
    @(posedge mclk);
    #1;
    req = '{wr: wr, rd: !wr, addr: addr, be: 4'hF >> (4 - n), wdata: data};
    @(posedge mclk);
    #1;
    req = '0;
  endtask

  task automatic read(input logic [7:0] addr, output logic [31:0] d, output logic v);
    put(1'b0, addr, 4, 32'h0000_0000);
    d = rdata;
    v = rvalid;
  endtask
endmodule

`default_nettype wire

// ==== sensor_status_control_register.sv ====
// status and control register bank with tare baseline and command decode
//
// Behaviour
// RL1 - Writes to read-only bits leave those bits unchanged.
// RL2 - Write-only bits always read back as zero.
// RL3 - Reserved bits read as zero and writes to them change nothing.
// RL4 - Unused bits store and return written values without affecting operation.
// RL5 - Bits with unknown reset state follow live sensor state without any write.
// RL6 - The upper sixteen bits of the status register always read as zero.
// RL7 - Writing code 2 to bits 15:14 resets the whole sensor; other codes do nothing.
// RL8 - Writing one to bit 13 clears the queue fault flag and the conversion flag.
// RL9 - With tare enabled the corrected pressure equals raw pressure minus the baseline.
// RL10 - Writing one to bit 11 copies corrected pressure into the tare baseline.
// RL11 - The master sends the register address byte then one to four data bytes LSB first.
// RL12 - The queue fault flag sets on a queue error while auto update is on and holds till cleared.
// RL13 - Command bits act once per qualifying write and are never latched.
// RL14 - All commands in one write are performed, and a reset overrides the others.
`timescale 1ns/10ps
`default_nettype none
`include "sscr_defs.svh"

module sensor_status_control_register (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire sscr_pkg::reg_req_t    req,
  input  wire sscr_pkg::sensor_state_t sensor,
  input  wire logic [31:0]           raw_pressure,
  input  wire logic                  queue_error_event,
  input  wire logic                  conversion_done,
  output logic [31:0]                rdata,
  output logic                       rvalid,
  output logic                       sensor_reset_pulse,
  output logic                       nv_write_pulse,
  output logic                       auto_update,
  output logic                       alternating_reading_enable,
  output logic                       tare_enable,
  output logic                       queue_fault_flag,
  output logic                       conversion_flag,
  output logic [31:0]                corrected_pressure_reg,
  output logic [31:0]                tare_baseline
);

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic        wr_status;
  logic        wr_base;
  logic        reset_cmd;
  logic        flag_clear_cmd;
  logic        capture_cmd;
  logic        nv_cmd;
  logic        clear_all;
  logic [31:0] status_word;

  assign wr_status = req.wr && (req.addr == `SSCR_ADDR_STATUS);
  assign wr_base   = req.wr && (req.addr == `SSCR_ADDR_TARE_BASE);

  // commands sit in byte 1 except nv write; a short write without that byte issues only the nv write
  assign reset_cmd = wr_status && req.be[1]
    && (req.wdata[`SSCR_RST_FIELD_HI:`SSCR_RST_FIELD_LO] == `SSCR_RST_CODE); // [RL7]
  // a same-access reset overrides every other command [RL14]
  assign flag_clear_cmd = wr_status && req.be[1] && req.wdata[`SSCR_BIT_FLAG_CLEAR]
    && !reset_cmd; // [RL8]
  assign capture_cmd = wr_status && req.be[1] && req.wdata[`SSCR_BIT_CAPTURE]
    && !reset_cmd; // [RL10]
  // nv transfer only honoured while configuration writes are permitted
  assign nv_cmd = wr_status && req.be[0] && req.wdata[`SSCR_BIT_NV_WRITE]
    && sensor.config_write_permit && !reset_cmd;

  // the commanded reset returns this bank to power-up state like the pin reset
  assign clear_all = rst || reset_cmd; // [RL7]

  // ------------------------------------------------------------
  // command pulses
  // ------------------------------------------------------------
  // registered one-cycle pulses, so nothing stays latched after the access [RL13]
  always_ff @(posedge mclk) begin
    if (rst) begin
      sensor_reset_pulse <= 1'h0;
      nv_write_pulse     <= 1'h0;
    end else begin
      sensor_reset_pulse <= reset_cmd; // [RL13]
      nv_write_pulse     <= nv_cmd;    // [RL13]
    end
  end

  // ------------------------------------------------------------
  // read/write mode bits
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      auto_update                <= 1'h0;
      alternating_reading_enable <= 1'h0;
      tare_enable                <= 1'h0;
    end else if (wr_status && req.be[1]) begin
      auto_update                <= req.wdata[`SSCR_BIT_AUTO];
      alternating_reading_enable <= req.wdata[`SSCR_BIT_ALT_READ];
      tare_enable                <= req.wdata[`SSCR_BIT_TARE];
    end
  end

  // ------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------
  // queue fault is read-only: a status write never loads it [RL1]
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      queue_fault_flag <= 1'h0;
    end else if (queue_error_event && auto_update) begin
      queue_fault_flag <= 1'h1; // [RL12]
    end else if (flag_clear_cmd) begin
      queue_fault_flag <= 1'h0; // [RL8]
    end
  end

  // a new conversion beats a clear in the same cycle so no result goes unflagged
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      conversion_flag <= `SSCR_RESET_CONVERSION;
    end else if (conversion_done) begin
      conversion_flag <= 1'h1;
    end else if (flag_clear_cmd) begin
      conversion_flag <= 1'h0; // [RL8]
    end else if (wr_status && req.be[0]) begin
      conversion_flag <= req.wdata[`SSCR_BIT_CONVERSION];
    end
  end

  // ------------------------------------------------------------
  // tare baseline and corrected pressure
  // ------------------------------------------------------------
  // every baseline bit is storage; the full word feeds the subtraction [RL4]
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      tare_baseline <= `SSCR_RESET_BASELINE;
    end else if (capture_cmd) begin
      tare_baseline <= corrected_pressure_reg; // [RL10]
    end else if (wr_base) begin
      for (int i = 0; i < 4; i++) begin
        if (req.be[i]) begin
          tare_baseline[i*8 +: 8] <= req.wdata[i*8 +: 8];
        end
      end
    end
  end

  // wraps modulo 2^32; a baseline above the reading gives a two's complement result
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      corrected_pressure_reg <= `SSCR_ZERO32;
    end else if (tare_enable) begin
      corrected_pressure_reg <= raw_pressure - tare_baseline; // [RL9]
    end else begin
      corrected_pressure_reg <= raw_pressure;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    status_word = `SSCR_ZERO32; // reserved, write-only and upper half read 0 [RL2] [RL3] [RL6]
    status_word[`SSCR_BIT_CONVERSION] = conversion_flag;
    status_word[`SSCR_BIT_VALID_HI:`SSCR_BIT_VALID_LO] = sensor.valid;  // [RL5]
    status_word[`SSCR_BIT_PERMIT]   = sensor.config_write_permit;       // [RL1]
    status_word[`SSCR_BIT_ADC_ON]   = sensor.adc_active;                // [RL5]
    status_word[`SSCR_BIT_AUTO]     = auto_update;
    status_word[`SSCR_BIT_ALT_READ] = alternating_reading_enable;
    status_word[`SSCR_BIT_QFAULT]   = queue_fault_flag;
    status_word[`SSCR_BIT_TARE]     = tare_enable;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata  <= `SSCR_ZERO32;
      rvalid <= 1'h0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        unique case (req.addr)
          `SSCR_ADDR_STATUS:    rdata <= status_word;
          `SSCR_ADDR_CORR_PRES: rdata <= corrected_pressure_reg;
          `SSCR_ADDR_TARE_BASE: rdata <= tare_baseline;
          default:              rdata <= `SSCR_ZERO32;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_upper_half_zero: assert property ( // [RL6]
    req.rd && req.addr == `SSCR_ADDR_STATUS |=> rdata[31:16] == 16'h0000)
    else $error("status upper half read nonzero");
  chk_wo_bits_zero: assert property ( // [RL2]
    req.rd && req.addr == `SSCR_ADDR_STATUS
    |=> rdata[15:13] == 3'h0 && rdata[11] == 1'h0 && rdata[7:5] == 3'h0)
    else $error("write-only or reserved status bit read nonzero");
  chk_reset_code: assert property ( // [RL7]
    wr_status && req.be[1] && req.wdata[15:14] == 2'h2
    |=> sensor_reset_pulse && !tare_enable && !queue_fault_flag && tare_baseline == 32'h0)
    else $error("reset code did not reset the bank");
  chk_other_codes: assert property ( // [RL7]
    wr_status && req.wdata[15:14] != 2'h2 |=> !sensor_reset_pulse)
    else $error("reset pulse on a non-reset code");
  chk_flag_clear: assert property ( // [RL8]
    flag_clear_cmd && !queue_error_event && !conversion_done
    |=> !queue_fault_flag && !conversion_flag)
    else $error("flag clear left a flag set");
  chk_qfault_sticky: assert property ( // [RL12]
    queue_fault_flag && !flag_clear_cmd && !reset_cmd |=> queue_fault_flag)
    else $error("queue fault dropped without clear");
  chk_qfault_set: assert property ( // [RL12]
    queue_error_event && auto_update && !reset_cmd |=> queue_fault_flag)
    else $error("queue fault not set");
  chk_ro_qfault: assert property ( // [RL1]
    wr_status && !queue_error_event && !flag_clear_cmd && !reset_cmd
    |=> queue_fault_flag == $past(queue_fault_flag))
    else $error("write changed read-only queue fault");
  chk_tare_subtract: assert property ( // [RL9]
    tare_enable && !reset_cmd && !capture_cmd && !wr_base
    |=> corrected_pressure_reg == $past(raw_pressure) - $past(tare_baseline))
    else $error("tared pressure wrong");
  chk_capture_copy: assert property ( // [RL10]
    capture_cmd |=> tare_baseline == $past(corrected_pressure_reg))
    else $error("baseline capture did not copy");
  chk_pulse_once: assert property ( // [RL13]
    sensor_reset_pulse && !reset_cmd |=> !sensor_reset_pulse)
    else $error("reset pulse latched");
  chk_reset_priority: assert property ( // [RL14]
    reset_cmd && req.wdata[13] && req.wdata[11] |=> tare_baseline == 32'h0 && !nv_write_pulse)
    else $error("command acted alongside reset");

  cov_reset:   cover property (reset_cmd);
  cov_capture: cover property (capture_cmd ##1 tare_enable);
  cov_qfault:  cover property (queue_fault_flag ##[1:20] flag_clear_cmd);
  cov_nv:      cover property (nv_write_pulse);

endmodule

`default_nettype wire

// ==== sscr_defs.svh ====
// offsets, field positions, reset values and codes of the status and control register
`ifndef SSCR_DEFS_SVH
`define SSCR_DEFS_SVH

`define SSCR_ADDR_STATUS      8'h00
`define SSCR_ADDR_CORR_PRES   8'h01
`define SSCR_ADDR_TARE_BASE   8'h57

`define SSCR_BIT_CONVERSION   0
`define SSCR_BIT_VALID_LO     1
`define SSCR_BIT_VALID_HI     2
`define SSCR_BIT_PERMIT       3
`define SSCR_BIT_ADC_ON       4
`define SSCR_BIT_NV_WRITE     5
`define SSCR_BIT_AUTO         8
`define SSCR_BIT_ALT_READ     9
`define SSCR_BIT_QFAULT       10
`define SSCR_BIT_CAPTURE      11
`define SSCR_BIT_TARE         12
`define SSCR_BIT_FLAG_CLEAR   13
`define SSCR_RST_FIELD_LO     14
`define SSCR_RST_FIELD_HI     15

`define SSCR_RST_CODE         2'h2
`define SSCR_ZERO32           32'h0000_0000
`define SSCR_RESET_CONVERSION 1'h0
`define SSCR_RESET_BASELINE   32'h0000_0000

`endif

// ==== sscr_pkg.sv ====
// types shared by the status and control register bank
package sscr_pkg;

  // one register access, as delivered by the serial front end after the address byte
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } reg_req_t;

  // live sensor state sampled into the status word
  typedef struct packed {
    logic       adc_active;
    logic [1:0] valid;
    logic       config_write_permit;
  } sensor_state_t;

endpackage

// ==== test_sensor_status_control_register.sv ====
// self-checking bench for the status and control register bank
`timescale 1ns/10ps
`default_nettype none
`include "sscr_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_sensor_status_control_register;
  logic mclk, rst, qev, cdone, rvalid, srst, nvw, auto_up, alt, tare, qff, cf;
  logic [31:0] raw, rdata, corr, base, d;
  logic v;
  int fails = 0, n_compared = 0;
  sscr_pkg::reg_req_t req;
  sscr_pkg::sensor_state_t sensor;

  sensor_status_control_register sensor_status_control_register_inst (
    .mclk(mclk), .rst(rst), .req(req), .sensor(sensor), .raw_pressure(raw),
    .queue_error_event(qev), .conversion_done(cdone), .rdata(rdata), .rvalid(rvalid),
    .sensor_reset_pulse(srst), .nv_write_pulse(nvw), .auto_update(auto_up),
    .alternating_reading_enable(alt), .tare_enable(tare), .queue_fault_flag(qff),
    .conversion_flag(cf), .corrected_pressure_reg(corr), .tare_baseline(base));

  reg_master_model reg_master_model_inst (
    .mclk(mclk), .rdata(rdata), .rvalid(rvalid), .req(req));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    reg_master_model_inst.read(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask

  task automatic wr(input int n, input logic [31:0] data);
    reg_master_model_inst.put(1'b1, `SSCR_ADDR_STATUS, n, data);
  endtask

  task automatic pulse(ref logic s);
    @(posedge mclk);
    #1 s = 1'b1;
    @(posedge mclk);
    #1 s = 1'b0;
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // a hang is cut short here and counted as a mismatch
  initial begin
    #2ms;
    fails++;
    complete_run();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    qev = 1'b0;
    cdone = 1'b0;
    raw = 32'h0000_0064;
    sensor = '{adc_active: 1'b1, valid: 2'h2, config_write_permit: 1'b0};
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    rd_chk(`SSCR_ADDR_STATUS, 32'h0000_0014);
    $display("test reset_state done");
    // all ones: reserved and read-only bits ignored, code 3 inert, capture of 100
    wr(4, 32'hFFFF_FFFF);
    `CHK(srst, 1'b0)
    `CHK(nvw, 1'b0)
    `CHK(base, 32'h0000_0064)
    rd_chk(`SSCR_ADDR_STATUS, 32'h0000_1314);
    raw = 32'h0000_00FA;
    repeat (2) @(posedge mclk);
    #1 `CHK(corr, 32'h0000_0096)
    rd_chk(`SSCR_ADDR_TARE_BASE, 32'h0000_0064);
    $display("test write_all_ones done");
    pulse(qev);
    pulse(cdone);
    rd_chk(`SSCR_ADDR_STATUS, 32'h0000_1715);
    wr(2, 32'h0000_3300);
    `CHK(qff, 1'b0)
    `CHK(cf, 1'b0)
    rd_chk(`SSCR_ADDR_STATUS, 32'h0000_1314);
    $display("test flag_clear done");
    for (int c = 0; c < 4; c++) begin
      if (c != 2) begin
        wr(2, (c << 14) | 32'h0000_1300);
        `CHK(srst, 1'b0)
        `CHK(tare, 1'b1)
      end
    end
    // reset code with capture and mode bits: reset must win
    wr(2, 32'h0000_BB00);
    `CHK(srst, 1'b1)
    `CHK(base, 32'h0000_0000)
    `CHK({tare, alt, auto_up}, 3'h0)
    @(posedge mclk);
    #1 `CHK(srst, 1'b0)
    $display("test reset_codes done");
    sensor.config_write_permit = 1'b1;
    wr(1, 32'h0000_0020);
    `CHK(nvw, 1'b1)
    @(posedge mclk);
    #1 `CHK(nvw, 1'b0)
    rd_chk(`SSCR_ADDR_STATUS, 32'h0000_001C);
    $display("test nv_write done");
    // auto update is off after the commanded reset, so a queue error must not flag
    pulse(qev);
    `CHK(qff, 1'b0)
    // two-byte baseline write lands in the low lanes only
    reg_master_model_inst.put(1'b1, `SSCR_ADDR_TARE_BASE, 2, 32'hAAAA_1234);
    rd_chk(`SSCR_ADDR_TARE_BASE, 32'h0000_1234);
    // the corrected pressure index is not writable
    reg_master_model_inst.put(1'b1, `SSCR_ADDR_CORR_PRES, 4, 32'h5555_5555);
    rd_chk(`SSCR_ADDR_CORR_PRES, 32'h0000_00FA);
    wr(2, 32'h0000_1000);
    raw = 32'h0000_1300;
    rd_chk(`SSCR_ADDR_CORR_PRES, 32'h0000_00CC);
    rd_chk(8'h02, 32'h0000_0000);
    $display("test baseline_write done");
    complete_run();
  end
endmodule

`default_nettype wire
